// File: abcs_dev.sv
// abcs_dev: converter mode sequencer (device end).
// assumes host keeps the link rules; analog is modelled by control outputs.
`timescale 1ns/10ps
module abcs_dev
  import abcs_pkg::*;
#(
  parameter int CONV_DIV = CONV_CLKS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // strap
  input  wire logic slave_mode,
  // link
  abcs_if.dev       lnk,
  // analog switch controls
  output logic      inputs_shorted,
  output logic      ref_connected,
  output logic      analog_powered
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_RUN   = 7'h01, ST_OFS = 7'h02, ST_GAIN = 7'h04, ST_FILL = 7'h08,
    ST_SLEEP = 7'h10, ST_PWR = 7'h20, ST_WCNV = 7'h40
  } abcs_st_t;

  logic [6:0] div_r, div_nxt;          // conversion period divider
  logic       conv_tick;               // one-cycle boundary pulse
  abcs_st_t   st_r, st_nxt;
  logic [2:0] mode_r, mode_nxt;        // mode in effect
  logic [2:0] pend_r, pend_nxt;        // mode written, waiting for boundary
  logic       pend_v_r, pend_v_nxt;
  logic [2:0] cnt_r, cnt_nxt;          // periods left in phase
  logic [3:0] pw_r, pw_nxt;            // power-up clocks
  logic       gain_next_r, gain_next_nxt; // fill leads to gain, not offset
  logic       first_ofs_r, first_ofs_nxt;
  logic       hold_r, hold_nxt;        // second post-wake cycle held high
  logic       awake_r, awake_nxt;
  logic       sd_q_r;                  // previous data line level
  logic       data_ready_n_r, data_ready_n_nxt;
  logic       sh_r, sh_nxt, rf_r, rf_nxt, pwr_r, pwr_nxt;

  assign conv_tick = (div_r == 7'(CONV_DIV - 1));
  assign lnk.data_ready_n = data_ready_n_r;
  assign lnk.port_awake   = awake_r;
  assign lnk.mode_cur     = mode_r;
  assign inputs_shorted   = sh_r;
  assign ref_connected    = rf_r;
  assign analog_powered   = pwr_r;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    // defaults: everything holds, the divider free-runs
    div_nxt       = conv_tick ? 7'h00 : div_r + 7'h01;
    st_nxt        = st_r;
    mode_nxt      = mode_r;
    pend_nxt      = pend_r;
    pend_v_nxt    = pend_v_r;
    cnt_nxt       = cnt_r;
    pw_nxt        = pw_r;
    gain_next_nxt = gain_next_r;
    first_ofs_nxt = first_ofs_r;
    hold_nxt      = hold_r;
    awake_nxt     = awake_r;
    sh_nxt        = sh_r;
    rf_nxt        = rf_r;
    pwr_nxt       = pwr_r;
    data_ready_n_nxt      = data_ready_n_r;
    // sleep wake-up of the serial port
    if (st_r == ST_SLEEP && !awake_r) begin
      if (!lnk.cs_n) begin
        // select low alone is enough, no command needed
        awake_nxt = 1'b1;
      end else if (sd_q_r && !lnk.sdata) begin
        // falling data line edge, select high
        awake_nxt = 1'b1;
      end else if (slave_mode && lnk.instr_stb) begin
        // slave with select high: any instruction
        awake_nxt = 1'b1;
      end
    end
    if (st_r == ST_SLEEP && awake_r && pend_v_r && pend_r != MODE_SLEEP) begin
      // the code stays queued so that it takes effect only after
      // the power-up and one whole conversion, not at once
      st_nxt  = ST_PWR;
      pw_nxt  = PWRUP_CLKS;
      pwr_nxt = 1'b1;
    end else if (st_r == ST_PWR) begin
      // power-up count, then wait for a clean period start
      if (pw_r != 4'h0) begin
        pw_nxt = pw_r - 4'h1;
      end else if (conv_tick) begin
        st_nxt = ST_WCNV;
      end
    end else if (conv_tick) begin
      data_ready_n_nxt = 1'b1;
      case (st_r)
        ST_WCNV: begin
          // first post-wake conversion done; second one held high too
          hold_nxt = 1'b1;
          st_nxt   = ST_RUN;
        end
        ST_OFS, ST_GAIN: begin
          if (cnt_r == 3'h1) begin
            // calibration over: reconnect input and refill the filter
            st_nxt        = ST_FILL;
            cnt_nxt       = FILL_PERIODS;
            sh_nxt        = 1'b0;
            rf_nxt        = 1'b0;
            gain_next_nxt = (st_r == ST_OFS);
          end else begin
            cnt_nxt = cnt_r - 3'h1;
          end
        end
        ST_FILL: begin
          if (cnt_r == 3'h1) begin
            // valid result; the next calibration starts this very cycle
            data_ready_n_nxt = 1'b0;
            cnt_nxt  = CAL_PERIODS;
            st_nxt   = gain_next_r ? ST_GAIN : ST_OFS;
            rf_nxt   = gain_next_r;
            sh_nxt   = !gain_next_r;
          end else begin
            cnt_nxt = cnt_r - 3'h1;
          end
        end
        default: begin
          // plain conversions; a held period after wake stays high
          data_ready_n_nxt = hold_r;
          hold_nxt = 1'b0;
          if (!hold_r) begin
            data_ready_n_nxt = (mode_r == MODE_NORMAL) ? 1'b0 : 1'b1;
          end
        end
      endcase
      // boundary: pending mode applied
      if (pend_v_r) begin
        pend_v_nxt = 1'b0;
        mode_nxt   = pend_r;
        if (pend_r == MODE_BGCAL) begin
          st_nxt        = ST_OFS;
          data_ready_n_nxt      = 1'b1;
          sh_nxt        = 1'b1;
          rf_nxt        = 1'b0;
          hold_nxt      = 1'b0;
          cnt_nxt       = (slave_mode && first_ofs_r) ? CAL_PERIODS_SL : CAL_PERIODS;
          first_ofs_nxt = 1'b0;
        end else if (pend_r == MODE_SLEEP) begin
          st_nxt    = ST_SLEEP;
          data_ready_n_nxt  = 1'b1;
          pwr_nxt   = 1'b0;
          sh_nxt    = 1'b0;
          rf_nxt    = 1'b0;
          awake_nxt = 1'b0;
        end else begin
          st_nxt = ST_RUN;
          sh_nxt = 1'b0;
          rf_nxt = 1'b0;
          if (pend_r != MODE_NORMAL) begin
            mode_nxt = MODE_NORMAL;
            data_ready_n_nxt = 1'b1;
          end
        end
      end else if (mode_r == MODE_BGCAL) begin
        mode_nxt = MODE_BGCAL;
      end
    end
    // writes only land while the port is awake; queued to a boundary.
    // placed after the apply so a write in the boundary cycle wins
    if (lnk.mode_we && awake_r) begin
      pend_nxt   = lnk.operation_mode_field;
      pend_v_nxt = 1'b1;
    end
    // one-shot calibrations are simplified: they finish in one cycle and
    // the mode in effect returns to normal; the field keeps the written code
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r       <= 7'h00;
      st_r        <= ST_RUN;
      mode_r      <= MODE_NORMAL;
      pend_r      <= MODE_NORMAL;
      pend_v_r    <= 1'b0;
      cnt_r       <= 3'h0;
      pw_r        <= 4'h0;
      gain_next_r <= 1'b0;
      first_ofs_r <= 1'b1;
      hold_r      <= 1'b0;
      awake_r     <= 1'b1;
      sd_q_r      <= 1'b0;
      data_ready_n_r      <= 1'b1;
      sh_r        <= 1'b0;
      rf_r        <= 1'b0;
      pwr_r       <= 1'b1;
    end else begin
      div_r       <= div_nxt;
      st_r        <= st_nxt;
      mode_r      <= mode_nxt;
      pend_r      <= pend_nxt;
      pend_v_r    <= pend_v_nxt;
      cnt_r       <= cnt_nxt;
      pw_r        <= pw_nxt;
      gain_next_r <= gain_next_nxt;
      first_ofs_r <= first_ofs_nxt;
      hold_r      <= hold_nxt;
      awake_r     <= awake_nxt;
      sd_q_r      <= lnk.sdata;
      data_ready_n_r      <= data_ready_n_nxt;
      sh_r        <= sh_nxt;
      rf_r        <= rf_nxt;
      pwr_r       <= pwr_nxt;
    end
  end
endmodule

// File: abcs_pkg.sv
// abcs_pkg: constants shared by the converter mode sequencer and its host end.
// assumes one 100 MHz clock; conversion cycles are enable pulses from a divider.
package abcs_pkg;
  // ------------------------------------------------------------
  // operation mode codes
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_SELFCAL = 3'h1;
  localparam logic [2:0] MODE_SYSOFS  = 3'h2;
  localparam logic [2:0] MODE_SYSFS   = 3'h3;
  localparam logic [2:0] MODE_PSEUDO  = 3'h4;
  localparam logic [2:0] MODE_BGCAL   = 3'h5;
  localparam logic [2:0] MODE_SLEEP   = 3'h6;
  // ------------------------------------------------------------
  // timing, in master clocks and conversion periods
  // ------------------------------------------------------------
  localparam int CONV_CLKS      = 64;  // master clocks per conversion period
  localparam logic [2:0] CAL_PERIODS    = 3'h3;
  localparam logic [2:0] CAL_PERIODS_SL = 3'h4;
  localparam logic [2:0] FILL_PERIODS   = 3'h3;
  localparam logic [3:0] PWRUP_CLKS     = 4'h8;
  localparam int WAKE_HIGH_CLKS = 2;   // least data-line high time before wake edge
  // ------------------------------------------------------------
  // host command port offsets
  // ------------------------------------------------------------
  localparam logic [3:0] HREG_MODE   = 4'h0;  // bits 2:0 mode, 3 bias, 4 ref
  localparam logic [3:0] HREG_WAKE   = 4'h1;  // write: bit0 cs, bit1 edge, bit2 instr
  localparam logic [3:0] HREG_STATUS = 4'h2;  // read: ready count and state
  localparam int MODE_BIAS_BIT = 3;
  localparam int MODE_REF_BIT  = 4;
endpackage

// File: abcs_if.sv
// abcs_if: link between host controller and converter mode sequencer.
// assumes both ends share clk; select and data line are single-driver here.
`timescale 1ns/10ps
interface abcs_if;
  logic       cs_n;           // chip select, low active
  logic       sdata;          // serial data line level as driven by host
  logic       instr_stb;      // instruction command pulse
  logic       mode_we;        // mode field write pulse
  logic [2:0] operation_mode_field;
  logic       bias_en;
  logic       internal_reference_enable;
  logic       data_ready_n;   // low for one conversion when data valid
  logic       port_awake;     // serial port responsive
  logic [2:0] mode_cur;       // mode in effect
  modport dev  (input cs_n, sdata, instr_stb, mode_we, operation_mode_field,
                bias_en, internal_reference_enable,
                output data_ready_n, port_awake, mode_cur);
  modport host (output cs_n, sdata, instr_stb, mode_we, operation_mode_field,
                bias_en, internal_reference_enable,
                input data_ready_n, port_awake, mode_cur);
endinterface

// File: abcs_host.sv
// abcs_host: host end; software drives it over a plain register port.
// assumes read data one cycle after read strobe.
`timescale 1ns/10ps
module abcs_host
  import abcs_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // software port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // link
  abcs_if.host            lnk
);
  logic [4:0] cfg_r, cfg_nxt;       // mode, bias, reference
  logic       we_r, we_nxt;
  logic       cs_r, cs_nxt, sd_r, sd_nxt, in_r, in_nxt;
  logic [1:0] hi_r, hi_nxt;         // data line high clock count
  logic [7:0] rd_r, rd_nxt;
  logic [5:0] cnt_r, cnt_nxt;       // ready pulses seen
  logic       dq_r;

  assign lnk.operation_mode_field      = cfg_r[2:0];
  assign lnk.bias_en                   = cfg_r[MODE_BIAS_BIT];
  assign lnk.internal_reference_enable = cfg_r[MODE_REF_BIT];
  assign lnk.mode_we = we_r;
  assign lnk.cs_n = cs_r;
  assign lnk.sdata = sd_r;
  assign lnk.instr_stb = in_r;
  assign rdata = rd_r;

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  always_comb begin
    cfg_nxt = cfg_r; we_nxt = 1'b0; in_nxt = 1'b0; cs_nxt = cs_r;
    sd_nxt = sd_r; hi_nxt = hi_r; rd_nxt = 8'h00; cnt_nxt = cnt_r;
    if (dq_r && !lnk.data_ready_n) cnt_nxt = cnt_r + 6'h01;
    // wake edge: high for three clocks then low
    if (sd_r && hi_r != 2'(WAKE_HIGH_CLKS)) hi_nxt = hi_r + 2'h1;
    else if (sd_r) begin
      sd_nxt = 1'b0; hi_nxt = 2'h0;
    end
    if (wr && addr == HREG_MODE) begin
      cfg_nxt = wdata[4:0]; we_nxt = 1'b1;
    end
    if (wr && addr == HREG_WAKE) begin
      cs_nxt = !wdata[0];
      if (wdata[1]) begin
        sd_nxt = 1'b1; hi_nxt = 2'h0;
      end
      in_nxt = wdata[2];
    end
    if (rd && addr == HREG_STATUS)
      rd_nxt = {lnk.port_awake, lnk.mode_cur, cnt_r[3:0]};
    else if (rd && addr == HREG_MODE)
      rd_nxt = {3'h0, cfg_r};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_r <= 5'h10; we_r <= 1'b0; cs_r <= 1'b1; sd_r <= 1'b0; in_r <= 1'b0;
      hi_r <= 2'h0; rd_r <= 8'h00; cnt_r <= 6'h00; dq_r <= 1'b1;
    end else begin
      cfg_r <= cfg_nxt; we_r <= we_nxt; cs_r <= cs_nxt; sd_r <= sd_nxt;
      in_r <= in_nxt; hi_r <= hi_nxt; rd_r <= rd_nxt; cnt_r <= cnt_nxt;
      dq_r <= lnk.data_ready_n;
    end
  end
endmodule

// File: abcs_assertions.sv
// abcs_assertions: timing checks on the host to sequencer link.
// assumes one clock, sync low reset, CONV_DIV equal to the device's.
`timescale 1ns/10ps
module abcs_assertions
  import abcs_pkg::*;
#(
  parameter int CONV_DIV = CONV_CLKS
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // link, host side
  input wire logic       cs_n,
  input wire logic       sdata,
  input wire logic       mode_we,
  input wire logic [2:0] operation_mode_field,
  // link, device side
  input wire logic       data_ready_n,
  input wire logic       port_awake,
  input wire logic [2:0] mode_cur
);
  // ----------------------------------------------------------
  // helper state
  // ----------------------------------------------------------
  localparam int APPLY = CONV_DIV + 2;  // write waits at most one period
  localparam int BG_LO = 5 * CONV_DIV;  // quiet part of the first loop
  localparam int BG_HI = 8 * CONV_DIV;  // slave first offset is one longer
  localparam int WAKE  = 2 * CONV_DIV;  // two conversions stay quiet
  logic        dr_q_r;    // ready, one clock late
  logic [2:0]  mode_q_r;  // mode, one clock late
  logic        clean_r;   // no mode change since last ready fall
  logic        wr_ok_r;   // accepted write since last mode change
  logic [19:0] gap_r;     // clocks since last ready fall
  logic [19:0] bg_r;      // clocks spent in background mode
  logic [19:0] wk_r;      // clocks since the wake-up mode write
  logic        fall;
  logic        chg;
  logic        take;
  assign fall = dr_q_r & ~data_ready_n;
  assign chg  = mode_q_r != mode_cur;
  assign take = mode_we & port_awake;
  // counters are wide enough for the whole run, so no saturation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dr_q_r   <= 1'b1;
      mode_q_r <= MODE_NORMAL;
      clean_r  <= 1'b0;
      wr_ok_r  <= 1'b0;
      gap_r    <= 20'h0;
      bg_r     <= 20'h0;
      wk_r     <= 20'h0;
    end else begin
      dr_q_r   <= data_ready_n;
      mode_q_r <= mode_cur;
      clean_r  <= chg ? 1'b0 : (fall ? 1'b1 : clean_r);
      wr_ok_r  <= chg ? take : (wr_ok_r | take);
      gap_r    <= fall ? 20'h1 : gap_r + 20'h1;
      bg_r     <= (mode_cur == MODE_BGCAL) ? bg_r + 20'h1 : 20'h0;
      wk_r     <= (take && mode_cur == MODE_SLEEP && operation_mode_field != MODE_SLEEP)
                  ? 20'h1 : ((wk_r != 20'h0) ? wk_r + 20'h1 : 20'h0);
    end
  end
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_BG_ENTRY: assert property (
    take && mode_cur == MODE_NORMAL && operation_mode_field == MODE_BGCAL
    |-> ##[1:APPLY] mode_cur == MODE_BGCAL) else $error("background mode late");
  AST_BG_QUIET: assert property (
    mode_cur == MODE_BGCAL && bg_r inside {[2:BG_LO]} |-> data_ready_n)
    else $error("ready low during first calibration");
  AST_BG_FIRST: assert property (
    $rose(mode_cur == MODE_BGCAL) |-> ##[BG_LO:BG_HI] !data_ready_n)
    else $error("no result after first offset loop");
  AST_BG_RATE: assert property (
    fall && clean_r && !chg && mode_cur == MODE_BGCAL |-> gap_r == 6 * CONV_DIV)
    else $error("background result spacing wrong");
  AST_SLEEP_ENTRY: assert property (
    take && mode_cur != MODE_SLEEP && operation_mode_field == MODE_SLEEP
    |-> ##[1:APPLY] mode_cur == MODE_SLEEP) else $error("sleep not entered");
  AST_SLEEP_QUIET: assert property (
    mode_cur == MODE_SLEEP |-> data_ready_n) else $error("ready low in sleep");
  AST_STICKY: assert property (
    chg && (mode_q_r == MODE_SLEEP || mode_q_r == MODE_BGCAL) |-> wr_ok_r)
    else $error("mode left without a write");
  AST_CS_WAKE: assert property (
    mode_cur == MODE_SLEEP && !port_awake && !cs_n |-> ##[1:4] port_awake)
    else $error("select did not wake port");
  AST_EDGE_WAKE: assert property (
    mode_cur == MODE_SLEEP && !port_awake && $fell(sdata) && $past(sdata, 2)
    |-> ##[1:4] port_awake) else $error("data edge did not wake port");
  AST_WAKE_QUIET: assert property (
    wk_r inside {[1:WAKE]} |-> data_ready_n) else $error("ready low too soon after wake");
  // main scenarios reached
  COV_BG_RESULT: cover property (fall && mode_cur == MODE_BGCAL && clean_r);
  COV_EDGE_WAKE: cover property (mode_cur == MODE_SLEEP && $fell(sdata));
  COV_WAKE_WR:   cover property (wk_r == 20'h1);
endmodule

// File: abcs_tb.sv
// abcs_tb: drives the host register port, judges the link and switches.
// assumes conversions shortened to 8 clocks by the device parameter.
`timescale 1ns/10ps
module abcs_tb import abcs_pkg::*; ();
  localparam int DIV = 8;  // short conversion keeps the run brief
  logic       clk = 1'b0, rst_n = 1'b0, slave_mode = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, rv;
  logic       inputs_shorted, ref_connected, analog_powered, dr_q;
  int         n_mismatch = 0, samples_checked = 0, n;
  always #5 clk = ~clk;
  abcs_if lnk ();
  abcs_dev #(.CONV_DIV(DIV)) i_abcs_dev (.clk(clk), .rst_n(rst_n), .slave_mode(slave_mode),
    .lnk(lnk), .inputs_shorted(inputs_shorted), .ref_connected(ref_connected),
    .analog_powered(analog_powered));
  abcs_host i_abcs_host (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .lnk(lnk));
  abcs_assertions #(.CONV_DIV(DIV)) i_abcs_assertions (.clk(clk), .rst_n(rst_n),
    .cs_n(lnk.cs_n), .sdata(lnk.sdata), .mode_we(lnk.mode_we),
    .operation_mode_field(lnk.operation_mode_field), .data_ready_n(lnk.data_ready_n),
    .port_awake(lnk.port_awake), .mode_cur(lnk.mode_cur));
  // ----------------------------------------------------------
  // compare, bus and wait helpers
  // ----------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("FAIL %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // data stand in the cycle after the strobe only
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  // clocks until the next high-to-low step of ready, capped at lim
  task automatic wait_fall(input int lim, output int cnt);
    cnt = 0;
    dr_q = lnk.data_ready_n;
    do begin
      @(posedge clk);
      #1 cnt++;
      if (dr_q === 1'b1 && lnk.data_ready_n === 1'b0) break;
      dr_q = lnk.data_ready_n;
    end while (cnt < lim);
    if (cnt >= lim) begin
      n_mismatch++;
      $display("FAIL %0t ready wait expired", $time);
      report_and_stop();
    end
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 40 * DIV; i++) begin
      @(posedge clk);
      #1 if (lnk.mode_cur === m) return;
    end
    n_mismatch++;
    $display("FAIL %0t mode wait expired", $time);
    report_and_stop();
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    rd_reg(HREG_MODE, rv);
    chk(rv, 8'h10);
    rd_reg(HREG_STATUS, rv);
    chk({rv[7:4], 4'h0}, 8'h80);
    rd_reg(4'hf, rv);  // unmapped place reads zero
    chk(rv, 8'h00);
  endtask
  // offset, fill, gain, fill: one result in six conversions
  task automatic t_bgcal();
    wr_reg(HREG_MODE, 8'h15);
    wait_mode(MODE_BGCAL);
    chk({7'h0, inputs_shorted}, 8'h01);
    wait_fall(10 * DIV, n);
    chk_n(n, 5 * DIV, 7 * DIV);
    chk({7'h0, ref_connected}, 8'h01);
    wait_fall(10 * DIV, n);
    chk_n(n, 6 * DIV, 6 * DIV);
    chk({7'h0, inputs_shorted}, 8'h01);
    wait_fall(10 * DIV, n);
    chk_n(n, 6 * DIV, 6 * DIV);
  endtask
  // sleep with bias and reference off, refused write, wake, back to normal
  task automatic t_sleep(input logic [7:0] wake);
    wr_reg(HREG_MODE, 8'h06);
    wait_mode(MODE_SLEEP);
    chk({7'h0, analog_powered}, 8'h00);
    chk({6'h0, lnk.bias_en, lnk.internal_reference_enable}, 8'h00);
    wr_reg(HREG_MODE, 8'h10);  // port still asleep: must be ignored
    repeat (4 * DIV) @(posedge clk);
    #1;
    chk({5'h0, lnk.mode_cur}, {5'h0, MODE_SLEEP});
    chk({7'h0, lnk.data_ready_n}, 8'h01);
    wr_reg(HREG_WAKE, wake);
    for (int i = 0; i < 20 && lnk.port_awake !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h0, lnk.port_awake}, 8'h01);
    wr_reg(HREG_MODE, 8'h18);
    wait_fall(12 * DIV, n);
    chk_n(n, 2 * DIV + 1, 12 * DIV - 1);
    chk({5'h0, lnk.mode_cur}, {5'h0, MODE_NORMAL});
    chk({6'h0, lnk.bias_en, lnk.internal_reference_enable}, 8'h03);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_bgcal();
    t_sleep(8'h02);
    @(posedge clk);
    slave_mode <= 1'b1;  // strap only changes under reset
    rst_n      <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n      <= 1'b1;
    t_sleep(8'h04);
    t_sleep(8'h01);
    report_and_stop();
  end
endmodule
